// ===== verilog/chan_state_pkg.sv
// Behaviour
// - Enabled channel event sets its pending bit.
// - Vector acknowledge clears that channel's pending bit.
// - Polled software clears pending by register write.
// - Mask bit zero masks, one unmasks.
// - Masked enabled channel still sets pending.
// - Masked channel never drives interrupt request.
// - Masking a requester drops its request at once; here the registered request output falls one cycle after the mask write.
// - Unmasked pending channel serviced by fixed priority.
// - Mask registers readable anytime without side effects.
// - Acknowledge sets in-service only when select set.
// - In-service clears on completion, select clear, write.
// - Ones mean pending/in-service; all reset to zero.
// - Register A layout: inputs 7,6, timers, serial.
// - Register B layout: inputs 5,4, timers C,D, 3-0.
// - End-of-interrupt options act only when vectoring.
// - Automatic and software end-of-interrupt modes offered.
// - Select one enables in-service, zero forces low.
// - In-service channel blocks lower priority requests.
// - Writing ones leaves in-service bits unchanged.
// - Four-bit channel code sets priority and vector.
`default_nettype none
package chan_state_pkg;
   // Channel count and code width; the code is the vector's low nibble.
   localparam int unsigned NUM_CH      = 16;
   localparam int unsigned CODE_W      = 4;
   // Bus geometry.
   localparam int unsigned ADDR_W      = 8;
   localparam int unsigned DATA_W      = 32;
   localparam int unsigned IDX_W       = 6;
   // Register indexes; the byte address is four times the index.
   localparam logic [IDX_W-1:0] PEND_A_IDX = 6'h0b;
   localparam logic [IDX_W-1:0] PEND_B_IDX = 6'h0d;
   localparam logic [IDX_W-1:0] SERV_A_IDX = 6'h0f;
   localparam logic [IDX_W-1:0] SERV_B_IDX = 6'h11;
   localparam logic [IDX_W-1:0] MASK_A_IDX = 6'h13;
   localparam logic [IDX_W-1:0] MASK_B_IDX = 6'h15;
   localparam logic [IDX_W-1:0] VECT_IDX   = 6'h17;
   // Values after reset.
   localparam logic [NUM_CH-1:0] CH_RESET  = 16'h0000;
   localparam logic [7:0]        VEC_RESET = 8'h00;
   // Vector control fields: upper vector nibble and in-service select.
   localparam int unsigned       VEC_S_BIT = 3;
   localparam logic [7:0]        VEC_WMASK = 8'hf8;
endpackage
`default_nettype wire

// ===== verilog/prio_if.sv
`timescale 1ns/1ns
`default_nettype none
// Carries the request vector to the priority picker and the winner back.
interface prio_if #(
   parameter int unsigned N = 16
);
   logic [N-1:0]         req;   // One bit per requesting channel.
   logic                 any;   // Some channel is requesting.
   logic [$clog2(N)-1:0] code;  // Code of the highest requester.
   modport enc  (input req, output any, output code);
   modport user (output req, input any, input code);
endinterface
`default_nettype wire

// ===== verilog/level_sync.sv
`timescale 1ns/1ns
`default_nettype none
// Two-stage synchroniser for a level arriving from a pin.
module level_sync #(
   parameter logic RESET_VAL = 1'b1
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta_q;  // First stage, read only by the second stage.

   // The second stage is the only reader of the first one.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q   <= RESET_VAL;
         sync_out <= RESET_VAL;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ===== verilog/prio_pick.sv
`timescale 1ns/1ns
`default_nettype none
// Picks the highest-coded requesting channel.
module prio_pick (
   prio_if.enc bus
);
   // Scanning upward lets the highest code overwrite lower ones.
   always_comb begin
      bus.any  = 1'b0;
      bus.code = '0;
      for (int i = 0; i < $bits(bus.req); i++) begin
         if (bus.req[i]) begin
            bus.any  = 1'b1;
            bus.code = ($bits(bus.code))'(i);
         end
      end
   end
endmodule
`default_nettype wire

// ===== verilog/interrupt_channel_state.sv
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// Pending, mask and in-service state for sixteen prioritised channels.
module interrupt_channel_state (
   input  wire logic                                 pclk,
   input  wire logic                                 presetn,
   input  wire logic                                 psel,
   input  wire logic                                 penable,
   input  wire logic                                 pwrite,
   input  wire logic [chan_state_pkg::ADDR_W-1:0]    paddr,
   input  wire logic [chan_state_pkg::DATA_W-1:0]    pwdata,
   input  wire logic [3:0]                           pstrb,
   output logic      [chan_state_pkg::DATA_W-1:0]    prdata,
   output logic                                      pready,
   output logic                                      pslverr,
   input  wire logic [chan_state_pkg::NUM_CH-1:0]    event_in,
   input  wire logic [chan_state_pkg::NUM_CH-1:0]    channel_enable_in,
   input  wire logic                                 acknowledge_strobe_in_n,
   output logic                                      interrupt_request,
   output logic      [7:0]                           vector_out,
   output logic                                      vector_valid
);
   import chan_state_pkg::*;

   // Channel state; bit n belongs to the channel with code n.
   logic [NUM_CH-1:0] pend_q;     // Pending bits.
   logic [NUM_CH-1:0] pend_d;     // Next pending bits.
   logic [NUM_CH-1:0] mask_q;     // Mask bits, one lets a channel request.
   logic [NUM_CH-1:0] serv_q;     // In-service bits.
   logic [NUM_CH-1:0] serv_d;     // Next in-service bits.
   logic [7:0]        vec_q;      // Vector nibble and in-service select.
   logic [NUM_CH-1:0] ev_en;      // Events on enabled channels.
   logic [NUM_CH-1:0] req;        // Channels now requesting service.
   logic [NUM_CH-1:0] pend_wclr;  // Pending bits cleared by software.
   logic [NUM_CH-1:0] serv_wclr;  // In-service bits cleared by software.
   logic [NUM_CH-1:0] ack_bit;    // One-hot of the acknowledged channel.
   logic [7:0]        rd_byte;    // Read data before its register.
   logic              rd_hit;     // Address names a register.
   logic              sel_soft;   // Software end-of-interrupt selected.
   logic              acc_cyc;    // Access phase still waiting.
   logic              wr_fire;    // Write completes at this edge.
   logic              ack_sync_n; // Synchronised acknowledge strobe.
   logic              ack_prev_q; // Acknowledge level one cycle ago.
   logic              ack_take;   // Start of an acknowledge cycle.
   logic              resp;       // A vector is returned this cycle.

   // Winner selection lives in its own module.
   prio_if #(.N(NUM_CH)) pick_if ();

   prio_pick u_pick (
      .bus (pick_if.enc)
   );

   // The acknowledge pin belongs to the processor, so it is synchronised.
   level_sync #(
      .RESET_VAL (1'b1)
   ) u_ack_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (acknowledge_strobe_in_n),
      .sync_out (ack_sync_n)
   );

   // Address decode, shared by read and write paths.
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                     input logic [IDX_W-1:0]  idx);
      addr_hit = (a[1:0] == 2'b00) && (a[ADDR_W-1:2] == idx);
   endfunction

   // Events only count on enabled channels.
   // enabled event capture.
   assign ev_en    = event_in & channel_enable_in;
   assign sel_soft = vec_q[VEC_S_BIT];

   // The request vector is built per channel.
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_req
         // A one mask bit lets a pending channel through; any in-service
         // bit at this code or above holds it back.
         // mask polarity here.
         assign req[g] = pend_q[g] & mask_q[g] & ~(|serv_q[NUM_CH-1:g]);
      end
   endgenerate

   assign pick_if.req = req;

   // An acknowledge starts when the synchronised strobe falls.
   assign ack_take = ~ack_sync_n & ~ack_prev_q;
   // Without a requesting channel the device stays silent.
   // priority picks pending.
   assign resp     = ack_take & pick_if.any;
   assign ack_bit  = {{(NUM_CH-1){1'b0}}, 1'b1} << pick_if.code;

   // The APB access phase waits one cycle so read data come from a flop.
   assign acc_cyc = psel & penable & ~pready;
   assign wr_fire = psel & penable & pready & pwrite & rd_hit & pstrb[0];

   // Software clears: a zero written clears, a one leaves the bit alone.
   always_comb begin
      pend_wclr = '0;
      serv_wclr = '0;
      if (wr_fire) begin
         if (addr_hit(paddr, PEND_A_IDX)) begin
            pend_wclr[15:8] = ~pwdata[7:0];
         end
         if (addr_hit(paddr, PEND_B_IDX)) begin
            pend_wclr[7:0] = ~pwdata[7:0];
         end
         if (addr_hit(paddr, SERV_A_IDX)) begin
            serv_wclr[15:8] = ~pwdata[7:0];
         end
         if (addr_hit(paddr, SERV_B_IDX)) begin
            serv_wclr[7:0] = ~pwdata[7:0];
         end
      end
   end

   // Next pending state; a new event wins over any clear in the same cycle.
   // Disabling a channel drops its pending bit, in-service is untouched.
   always_comb begin
      pend_d = pend_q & ~pend_wclr;
      if (resp) begin
         pend_d = pend_d & ~ack_bit;
      end
      pend_d = (pend_d & channel_enable_in) | ev_en;
   end

   // Next in-service state. Polled systems never acknowledge, so the
   // select bit then changes nothing here or in the request gating.
   // only acknowledge sets.
   always_comb begin
      if (!sel_soft) begin
         serv_d = '0;
      end else begin
         serv_d = serv_q & ~serv_wclr;
         if (resp) begin
            serv_d = serv_d | ack_bit;
         end
      end
   end

   // Pending register pair.
   // reset to zero.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_q <= CH_RESET;
      end else begin
         pend_q <= pend_d;
      end
   end

   // In-service register pair.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serv_q <= CH_RESET;
      end else begin
         serv_q <= serv_d;
      end
   end

   // Mask registers and vector control take plain writes.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= CH_RESET;
         vec_q  <= VEC_RESET;
      end else if (wr_fire) begin
         if (addr_hit(paddr, MASK_A_IDX)) begin
            mask_q[15:8] <= pwdata[7:0];
         end
         if (addr_hit(paddr, MASK_B_IDX)) begin
            mask_q[7:0] <= pwdata[7:0];
         end
         // Unused low bits are never stored, so they read as zero.
         if (addr_hit(paddr, VECT_IDX)) begin
            vec_q <= pwdata[7:0] & VEC_WMASK;
         end
      end
   end

   // Read multiplexer. Register A carries codes 15 to 8, so its bit 7 is
   // general input 7 and bit 0 timer B; register B carries codes 7 to 0.
   // register A layout.
   always_comb begin
      rd_hit  = 1'b1;
      rd_byte = 8'h00;
      if (addr_hit(paddr, PEND_A_IDX)) begin
         rd_byte = pend_q[15:8];
      end else if (addr_hit(paddr, PEND_B_IDX)) begin
         rd_byte = pend_q[7:0];
      end else if (addr_hit(paddr, SERV_A_IDX)) begin
         rd_byte = serv_q[15:8];
      end else if (addr_hit(paddr, SERV_B_IDX)) begin
         rd_byte = serv_q[7:0];
      end else if (addr_hit(paddr, MASK_A_IDX)) begin
         rd_byte = mask_q[15:8];
      end else if (addr_hit(paddr, MASK_B_IDX)) begin
         rd_byte = mask_q[7:0];
      end else if (addr_hit(paddr, VECT_IDX)) begin
         rd_byte = vec_q;
      end else begin
         // Unmapped addresses answer with an error and zero data.
         rd_hit = 1'b0;
      end
   end

   // APB answer: pready rises one cycle into the access phase and falls
   // with the completing edge; reads never change any state.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= acc_cyc;
         pslverr <= acc_cyc & ~rd_hit;
         if (acc_cyc && !pwrite) begin
            prdata <= {{(DATA_W-8){1'b0}}, rd_byte};
         end
      end
   end

   // Acknowledge edge memory.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_prev_q <= 1'b0;
      end else begin
         ack_prev_q <= ~ack_sync_n;
      end
   end

   // Vector answer: a one-cycle strobe with the vector beside it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vector_valid <= 1'b0;
         vector_out   <= 8'h00;
      end else begin
         vector_valid <= resp;
         if (resp) begin
            vector_out <= {vec_q[7:4], pick_if.code};
         end
      end
   end

   // Request output. Being registered, it trails a mask write by one
   // cycle, which is the price of a glitch-free output.
   // masked channels excluded.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interrupt_request <= 1'b0;
      end else begin
         interrupt_request <= |req;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_pend_set: assert property (
      1'b1 |=> ((pend_q & $past(ev_en)) == $past(ev_en)))
      else $error("event on enabled channel did not set pending");

   a_ack_clear: assert property (
      resp && !ev_en[pick_if.code] |=> !pend_q[vector_out[CODE_W-1:0]])
      else $error("acknowledged channel still pending");

   a_poll_clear: assert property (
      wr_fire && addr_hit(paddr, PEND_A_IDX) && !pwdata[0] && !ev_en[8]
      |=> !pend_q[8])
      else $error("pending write of zero did not clear");

   a_mask_gate: assert property (
      ((pend_q & mask_q) == '0) |=> !interrupt_request)
      else $error("request raised with no unmasked pending channel");

   a_mask_read: assert property (
      acc_cyc && !pwrite && addr_hit(paddr, MASK_A_IDX)
      |=> pready && (prdata[7:0] == $past(mask_q[15:8])))
      else $error("mask read returned wrong data");

   a_serv_set: assert property (
      resp && sel_soft |=> serv_q[vector_out[CODE_W-1:0]] && vector_valid)
      else $error("in-service bit not set on acknowledge");

   a_serv_auto: assert property (
      !sel_soft |=> (serv_q == '0))
      else $error("in-service bits not forced low");

   a_serv_ones: assert property (
      wr_fire && addr_hit(paddr, SERV_A_IDX) && (pwdata[7:0] == 8'hff)
      && !resp && sel_soft |=> (serv_q == $past(serv_q)))
      else $error("writing ones altered in-service bits");

   a_lower_block: assert property (
      ack_take && pick_if.any |-> ((serv_q >> pick_if.code) == '0))
      else $error("vector passed below an in-service channel");

   // Clearing every mask bit must silence the request output one cycle
   // after the write lands; the register stage on the output costs that cycle.
   a_mask_drop: assert property (
      wr_fire && addr_hit(paddr, MASK_A_IDX) && (pwdata[7:0] == 8'h00)
      && (mask_q[7:0] == 8'h00) |=> ##1 !interrupt_request)
      else $error("request still raised after all masks cleared");

   // A zero written to an in-service bit clears it, unless an acknowledge
   // sets a bit in the same cycle, since the set wins.
   a_serv_wclear: assert property (
      wr_fire && addr_hit(paddr, SERV_B_IDX) && !resp
      |=> ((serv_q[7:0] & ~$past(pwdata[7:0])) == 8'h00))
      else $error("in-service bit survived a clearing write");

   // The vector carries the stored nibble above the winner's code.
   a_vec_code: assert property (
      resp |=> vector_valid
      && (vector_out == {$past(vec_q[7:4]), $past(pick_if.code)}))
      else $error("vector does not match the winning channel");

   // A mask write stores the written byte as it stands.
   a_mask_write: assert property (
      wr_fire && addr_hit(paddr, MASK_B_IDX)
      |=> (mask_q[7:0] == $past(pwdata[7:0])))
      else $error("mask write not stored");

   // Reads never disturb the masks, however often software polls them.
   a_read_quiet: assert property (
      psel && !pwrite |=> (mask_q == $past(mask_q)))
      else $error("read changed the mask registers");

endmodule
`default_nettype wire

// ===== tb/host_ack_model.sv
`timescale 1ns/1ns
`default_nettype none
// Host side of the vectored acknowledge: pulls the pin low and catches the vector.
module host_ack_model (
   input  wire logic       pclk,
   input  wire logic       go,
   input  wire logic       vector_valid,
   input  wire logic [7:0] vector_out,
   output logic            ack_n,
   output logic            busy,
   output logic            seen,
   output logic [7:0]      got
);
   // The pin idles high, so no false edge is seen across reset release.
   initial begin
      ack_n = 1'b1;
      busy = 1'b0;
      seen = 1'b0;
      got = 8'h00;
      forever begin
         @(posedge pclk);
         if (go) begin
            busy <= 1'b1;
            seen <= 1'b0;
            ack_n <= 1'b0;
            // A fixed window; an idle device never answers, so no wait on it.
            for (int i = 0; i < 12; i++) begin
               @(posedge pclk);
               if (vector_valid === 1'b1) begin
                  got <= vector_out;
                  seen <= 1'b1;
               end
            end
            ack_n <= 1'b1;
            // The pin must stay high a few cycles before the next cycle.
            repeat (3) @(posedge pclk);
            busy <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ===== tb/interrupt_channel_state_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
   $display("BAD t=%0t got %h exp %h", $time, a, b); end end
// Drives registers over APB and events, and checks request and vector.
module interrupt_channel_state_tb_top;
   import chan_state_pkg::*;
   typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] x; logic e;} row_s;
   localparam logic [7:0] PA = {PEND_A_IDX, 2'b00};
   localparam logic [7:0] PB = {PEND_B_IDX, 2'b00};
   localparam logic [7:0] SA = {SERV_A_IDX, 2'b00};
   localparam logic [7:0] SB = {SERV_B_IDX, 2'b00};
   localparam logic [7:0] MA = {MASK_A_IDX, 2'b00};
   localparam logic [7:0] MB = {MASK_B_IDX, 2'b00};
   localparam logic [7:0] VC = {VECT_IDX, 2'b00};
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, vector_out, got;
   logic [31:0] pwdata, prdata, r;
   logic [15:0] event_in, channel_enable_in;
   logic [3:0]  pstrb;
   logic        ack_n, irq, vector_valid, go, busy, seen, e;
   int          bad_count, total_checks;
   row_s        rows [6];
   interrupt_channel_state DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .event_in(event_in), .channel_enable_in(channel_enable_in),
      .acknowledge_strobe_in_n(ack_n), .interrupt_request(irq),
      .vector_out(vector_out), .vector_valid(vector_valid));
   host_ack_model HOST (.pclk(pclk), .go(go), .vector_valid(vector_valid),
      .vector_out(vector_out), .ack_n(ack_n), .busy(busy), .seen(seen), .got(got));
   // Free-running clock.
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // Prints the counts and the verdict, then ends the run.
   task automatic summarize();
      $display("checks %0d bad %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // One APB transfer; holds the request until pready is sampled high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         bad_count++;
         summarize();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Reads one register and compares the whole word with the byte zero-extended.
   task automatic rdc(input logic [7:0] a, input logic [7:0] x);
      apb(1'b0, a, 32'h0);
      `CHK(r, {24'h0, x})
   endtask
   // Pulses events for one cycle, then lets the request settle.
   task automatic evt(input logic [15:0] v);
      event_in <= v;
      @(posedge pclk);
      event_in <= 16'h0000;
      repeat (3) @(posedge pclk);
   endtask
   // Asks the host for one acknowledge cycle and waits, bounded, for its end.
   task automatic ack();
      int n;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while ((busy !== 1'b0 || n < 3) && n < 40);
      if (n >= 40) begin
         bad_count++;
         summarize();
      end
   endtask
   // Main sequence: reset, register table, then hand-written cases.
   initial begin
      {psel, penable, pwrite, go} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      event_in = 16'h0000;
      channel_enable_in = 16'hffff;
      pstrb = 4'hf;
      presetn = 1'b0;
      rows = '{'{MA, 8'ha5, 8'ha5, 1'b0}, '{MB, 8'h5a, 8'h5a, 1'b0},
               '{PA, 8'hff, 8'h00, 1'b0}, '{SA, 8'hff, 8'h00, 1'b0},
               '{VC, 8'hff, 8'hf8, 1'b0}, '{8'h2d, 8'hff, 8'h00, 1'b1}};
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (rows[i]) rdc(rows[i].a, 8'h00);
      $display("reset values done");
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, {24'h0, rows[i].d});
         rdc(rows[i].a, rows[i].x);
         `CHK(e, rows[i].e)
      end
      apb(1'b1, MA, 32'h0);
      apb(1'b1, MB, 32'h0);
      apb(1'b1, VC, 32'h0);
      $display("register table done");
      // Masked channels still go pending but never request.
      evt(16'h2004);
      rdc(PA, 8'h20);
      rdc(PB, 8'h04);
      `CHK(irq, 1'b0)
      apb(1'b1, MA, 32'h20);
      repeat (3) @(posedge pclk);
      `CHK(irq, 1'b1)
      apb(1'b1, MA, 32'h0);
      repeat (2) @(posedge pclk);
      `CHK(irq, 1'b0)
      apb(1'b1, PA, 32'hdf);
      rdc(PA, 8'h00);
      rdc(PB, 8'h04);
      rdc(SA, 8'h00);
      // An event on a disabled channel must leave no pending trace.
      channel_enable_in <= 16'hdfff;
      evt(16'h2000);
      rdc(PA, 8'h00);
      channel_enable_in <= 16'hffff;
      $display("mask and polled done");
      // Automatic end of interrupt: highest code first, no in-service trace.
      apb(1'b1, VC, 32'h40);
      evt(16'h2000);
      apb(1'b1, MA, 32'h20);
      apb(1'b1, MB, 32'h04);
      ack();
      `CHK(got, 8'h4d)
      rdc(PA, 8'h00);
      rdc(SA, 8'h00);
      ack();
      `CHK(got, 8'h42)
      rdc(PB, 8'h00);
      ack();
      `CHK(seen, 1'b0)
      $display("automatic mode done");
      // Software end of interrupt: in-service blocks lower codes, not higher ones.
      apb(1'b1, VC, 32'h48);
      apb(1'b1, MB, 32'h06);
      evt(16'h0004);
      ack();
      `CHK(got, 8'h42)
      rdc(SB, 8'h04);
      evt(16'h0002);
      `CHK(irq, 1'b0)
      evt(16'h2000);
      `CHK(irq, 1'b1)
      ack();
      `CHK(got, 8'h4d)
      rdc(SA, 8'h20);
      apb(1'b1, SA, 32'hff);
      rdc(SA, 8'h20);
      apb(1'b1, SA, 32'hdf);
      rdc(SA, 8'h00);
      apb(1'b1, SB, 32'hfb);
      repeat (3) @(posedge pclk);
      `CHK(irq, 1'b1)
      ack();
      `CHK(got, 8'h41)
      rdc(SB, 8'h02);
      apb(1'b1, VC, 32'h40);
      rdc(SB, 8'h00);
      $display("software mode done");
      // A write without its low byte strobe must not land.
      pstrb <= 4'h0;
      apb(1'b1, MA, 32'hff);
      pstrb <= 4'hf;
      rdc(MA, 8'h20);
      // Reset in mid-run with a live request: everything returns to zero.
      evt(16'h2000);
      `CHK(irq, 1'b1)
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      `CHK(irq, 1'b0)
      presetn <= 1'b1;
      @(posedge pclk);
      `CHK(irq, 1'b0)
      rdc(PA, 8'h00);
      rdc(MA, 8'h00);
      $display("strobe and reset done");
      summarize();
   end
endmodule
`default_nettype wire
